/* File: hw/tfhs_pkg.sv */
// Package: constants for the frame header and sequence block
package tfhs_pkg;
    // ------------------------------------------------------------
    // Control byte layout
    // ------------------------------------------------------------
    localparam logic [1:0] FT_APPL  = 2'h0;
    localparam logic [1:0] FT_RSVD  = 2'h1;
    localparam logic [1:0] FT_PRIV  = 2'h2;
    localparam logic [1:0] FT_CTRL  = 2'h3;
    localparam logic [1:0] RT_LINK  = 2'h0;
    localparam logic [1:0] RT_TOTAL = 2'h1;
    localparam logic [1:0] RT_RSVD  = 2'h2;
    localparam logic [1:0] RT_ABS   = 2'h3;
    localparam int FT_POS  = 2;
    localparam int EXT_BIT = 7;
    // ------------------------------------------------------------
    // Field limits
    // ------------------------------------------------------------
    localparam int PATH_MAX   = 4;
    localparam int CHAN_MAX   = 2;
    localparam int ADDR_MIN   = 2;
    localparam int DATA_MAX   = 128;
    localparam int SHORT_MAX  = 32;
    localparam int DATA_ALIGN = 8;
    localparam logic [7:0] SEQ_RESET = 8'h00;
    // Alert codes reported to link error recovery
    localparam logic [1:0] ALERT_NONE   = 2'h0;
    localparam logic [1:0] ALERT_SEQ    = 2'h1;
    localparam logic [1:0] ALERT_REJECT = 2'h2;
    // Parser states, Gray coded along the path
    typedef enum logic [2:0] {
        ST_CTRL = 3'h0,
        ST_PATH = 3'h1,
        ST_CHAN = 3'h3,
        ST_DATA = 3'h2,
        ST_STAT = 3'h6,
        ST_EXT  = 3'h7,
        ST_SKIP = 3'h5
    } tfhs_state_t;
endpackage : tfhs_pkg

/* File: hw/tfhs_frame.sv */
// Receive header parser, sequence counters and transmit sequence insertion
// Behaviour
// [RULE1] Frame type 00 application, 01 reserved, 10 privileged, 11 control.
// [RULE2] Control reset type 00 link, 01 total, 11 absolute, 10 reserved.
// [RULE3] Total reset reinitialises state; absolute also may request self test.
// [RULE4] Two-bit transmit counter copied into sequence field, cleared when disabled.
// [RULE5] Transmit counter advances on closing flag of non-control unaborted frame.
// [RULE6] Receive counter cleared when disabled, advances on valid non-control frames.
// [RULE7] Matching sequence number accepts frame and acknowledges unless other error.
// [RULE8] Mismatch withholds acknowledgment, starts recovery with sequence alert.
// [RULE9] Forwarded frames get the outgoing link's counter in sequence field.
// [RULE10] Counters may widen to eight bits; low two bits in sequence field.
// [RULE11] Routers forward any control pattern if sequence number matches.
// [RULE12] Reserved frame or reset type starts recovery with frame-reject alert.
// [RULE13] Link reset carries status byte, extended adds receive count byte.
// [RULE14] Total and absolute reset carry a path field after control.
// [RULE15] Address follows control, two to six bytes, path then channel.
// [RULE16] Continuation bit set extends component; clear ends path then channel.
// [RULE17] Each address byte holds a seven-bit index.
// [RULE18] Continuation in bit seven, index in bits six to zero.
// [RULE19] Routers decrement first path byte, switches may delete it.
// [RULE20] Path one to four bytes, channel one to two; buffers sized.
// [RULE21] Channel zero always receives short messages.
// [RULE22] Data field zero to 128 bytes follows the address field.
// [RULE23] Non-final data frames are multiples of eight bytes; may reject.
// [RULE24] One short message per frame, data at most 32 bytes.
`timescale 1ns/1ns
module tfhs_frame #(
    parameter int SEQ_W = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             link_disabled,
    input  wire logic             ext_enable,
    input  wire logic             router_mode,
    input  wire logic             rx_valid,
    input  wire logic [7:0]       rx_byte,
    input  wire logic             rx_start,
    input  wire logic             rx_end,
    input  wire logic             rx_abort,
    input  wire logic             rx_crc_ok,
    input  wire logic             rx_last_xfer,
    input  wire logic             tx_in_valid,
    output logic                  tx_in_ready,
    input  wire logic [7:0]       tx_in_byte,
    input  wire logic             tx_in_first,
    input  wire logic             tx_end,
    input  wire logic             tx_abort,
    output logic                  tx_out_valid,
    input  wire logic             tx_out_ready,
    output logic [7:0]            tx_out_byte,
    output logic                  rx_ack,
    output logic                  rx_accept,
    output logic                  rx_forward,
    output logic                  link_error_recovery,
    output logic [1:0]            alert_code,
    output logic                  total_reset,
    output logic                  absolute_reset,
    output logic                  power_on_self_test,
    output logic                  link_reset_rx,
    output logic [7:0]            link_status,
    output logic [7:0]            ext_rx_count_field,
    output logic [6:0]            path_index [tfhs_pkg::PATH_MAX],
    output logic [2:0]            path_len,
    output logic [13:0]           channel,
    output logic                  short_message,
    output logic [7:0]            data_len,
    output logic [SEQ_W-1:0]      tx_seq,
    output logic [SEQ_W-1:0]      rx_seq
);
    // Refuse counter widths that the sequence field cannot serve
    if (SEQ_W < 2 || SEQ_W > 8) begin : g_seq_w_check
        $error("SEQ_W must be 2..8");
    end

    // ------------------------------------------------------------
    // Control byte decode
    // ------------------------------------------------------------
    wire logic [1:0] ftype_w = rx_byte[tfhs_pkg::FT_POS +: 2];   // [RULE1]
    wire logic [1:0] low2_w  = rx_byte[1:0];
    wire logic       ext_w   = rx_byte[tfhs_pkg::EXT_BIT];        // [RULE18]
    wire logic [6:0] idx_w   = rx_byte[6:0];                      // [RULE17]
    wire logic       hdr_w   = rx_valid & rx_start;
    // Routers hand on the first path hop already used up by this node
    wire logic [6:0] path_in_w = (router_mode && path_len == 3'h0 && idx_w != 7'h00) ?
                                 idx_w - 7'h01 : idx_w;               // [RULE19]

    tfhs_pkg::tfhs_state_t state_reg;
    tfhs_pkg::tfhs_state_t state_next;
    logic [1:0]  ftype_reg;
    logic [1:0]  rtype_reg;
    logic        seq_bad_reg;
    logic        reject_reg;
    logic [2:0]  addr_cnt_reg;
    logic [1:0]  chan_cnt_reg;
    logic [7:0]  dcnt_reg;

    wire logic is_ctrl_w = (ftype_reg == tfhs_pkg::FT_CTRL);
    wire logic [1:0] rx_low_w = rx_seq[1:0];

    // Next parser state from current byte
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            tfhs_pkg::ST_CTRL: begin
                if (hdr_w && ftype_w != tfhs_pkg::FT_CTRL) begin
                    state_next = tfhs_pkg::ST_PATH;                 // [RULE15]
                end else if (hdr_w && (low2_w == tfhs_pkg::RT_TOTAL ||
                                       low2_w == tfhs_pkg::RT_ABS)) begin
                    state_next = tfhs_pkg::ST_PATH;                 // [RULE14]
                end else if (hdr_w && low2_w == tfhs_pkg::RT_LINK) begin
                    state_next = tfhs_pkg::ST_STAT;                 // [RULE13]
                end else if (hdr_w) begin
                    state_next = tfhs_pkg::ST_SKIP;
                end
            end
            tfhs_pkg::ST_PATH: begin
                if (rx_valid && !ext_w) begin
                    state_next = is_ctrl_w ? tfhs_pkg::ST_SKIP : tfhs_pkg::ST_CHAN; // [RULE16]
                end
            end
            tfhs_pkg::ST_CHAN: begin
                if (rx_valid && !ext_w) begin
                    state_next = tfhs_pkg::ST_DATA;                 // [RULE22]
                end
            end
            tfhs_pkg::ST_STAT: begin
                if (rx_valid) begin
                    state_next = ext_enable ? tfhs_pkg::ST_EXT : tfhs_pkg::ST_SKIP;
                end
            end
            tfhs_pkg::ST_EXT: begin
                if (rx_valid) begin
                    state_next = tfhs_pkg::ST_SKIP;
                end
            end
            tfhs_pkg::ST_DATA: state_next = tfhs_pkg::ST_DATA;
            tfhs_pkg::ST_SKIP: state_next = tfhs_pkg::ST_SKIP;
            default: state_next = tfhs_pkg::ST_CTRL;
        endcase
        if (rx_end || rx_abort) begin
            state_next = tfhs_pkg::ST_CTRL;
        end
    end

    // ------------------------------------------------------------
    // Frame end checks
    // ------------------------------------------------------------
    wire logic len_bad_w = (dcnt_reg > 8'(tfhs_pkg::DATA_MAX)) ||        // [RULE22]
                           (short_message && dcnt_reg > 8'(tfhs_pkg::SHORT_MAX)) || // [RULE24]
                           (!short_message && !rx_last_xfer &&
                            dcnt_reg[2:0] != 3'h0);                   // [RULE23]
    wire logic addr_bad_w = !is_ctrl_w && (addr_cnt_reg < 3'(tfhs_pkg::ADDR_MIN) ||
                            state_reg != tfhs_pkg::ST_DATA);          // [RULE15]
    wire logic ctrl_data_w = is_ctrl_w && state_reg == tfhs_pkg::ST_DATA;
    wire logic frame_end_w = rx_end && !rx_abort && rx_crc_ok;
    wire logic other_err_w = reject_reg || len_bad_w || addr_bad_w || ctrl_data_w;
    wire logic good_w      = frame_end_w && !is_ctrl_w && !seq_bad_reg && !other_err_w;
    wire logic fwd_w       = frame_end_w && router_mode && !seq_bad_reg;   // [RULE11]
    wire logic erp_w       = frame_end_w && !router_mode &&
                             (seq_bad_reg || other_err_w);
    wire logic ctrl_ok_w   = frame_end_w && is_ctrl_w && !other_err_w && !router_mode;
    wire logic seq_adv_w   = rx_end && !rx_abort && rx_crc_ok && !is_ctrl_w &&
                             !seq_bad_reg && !other_err_w;             // [RULE6]

    // ------------------------------------------------------------
    // Header registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg    <= tfhs_pkg::ST_CTRL;
            ftype_reg    <= tfhs_pkg::FT_APPL;
            rtype_reg    <= tfhs_pkg::RT_LINK;
            seq_bad_reg  <= 1'b0;
            reject_reg   <= 1'b0;
            addr_cnt_reg <= 3'h0;
            chan_cnt_reg <= 2'h0;
            dcnt_reg     <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (hdr_w) begin
                ftype_reg    <= ftype_w;
                rtype_reg    <= low2_w;
                seq_bad_reg  <= (ftype_w != tfhs_pkg::FT_CTRL) && (low2_w != rx_low_w); // [RULE8]
                reject_reg   <= (ftype_w == tfhs_pkg::FT_RSVD) ||
                                (ftype_w == tfhs_pkg::FT_CTRL &&
                                 low2_w == tfhs_pkg::RT_RSVD);      // [RULE12]
                addr_cnt_reg <= 3'h0;
                chan_cnt_reg <= 2'h0;
                dcnt_reg     <= 8'h00;
            end else if (rx_valid) begin
                if (state_reg == tfhs_pkg::ST_PATH || state_reg == tfhs_pkg::ST_CHAN) begin
                    addr_cnt_reg <= addr_cnt_reg + 3'h1;
                end
                if (state_reg == tfhs_pkg::ST_CHAN) begin
                    chan_cnt_reg <= chan_cnt_reg + 2'h1;
                end
                if (state_reg == tfhs_pkg::ST_DATA && dcnt_reg != 8'hFF) begin
                    dcnt_reg <= dcnt_reg + 8'h01;
                end
            end
        end
    end

    // Path and channel capture, buffers sized for maximum lengths
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            path_len <= 3'h0;
            channel  <= 14'h0000;
            for (int i = 0; i < tfhs_pkg::PATH_MAX; i++) begin
                path_index[i] <= 7'h00;
            end
        end else if (hdr_w) begin
            path_len <= 3'h0;
            channel  <= 14'h0000;
        end else if (rx_valid && state_reg == tfhs_pkg::ST_PATH &&
                     path_len < 3'(tfhs_pkg::PATH_MAX)) begin
            path_index[path_len[1:0]] <= path_in_w;                   // [RULE20]
            path_len <= path_len + 3'h1;
        end else if (rx_valid && state_reg == tfhs_pkg::ST_CHAN &&
                     chan_cnt_reg < 2'(tfhs_pkg::CHAN_MAX)) begin
            channel <= {channel[6:0], idx_w};                         // [RULE20]
        end
    end

    // Link reset status and extended count capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            link_status        <= 8'h00;
            ext_rx_count_field <= 8'h00;
        end else if (rx_valid && state_reg == tfhs_pkg::ST_STAT) begin
            link_status <= rx_byte;                                   // [RULE13]
        end else if (rx_valid && state_reg == tfhs_pkg::ST_EXT) begin
            ext_rx_count_field <= rx_byte;                            // [RULE10]
        end
    end

    // Channel zero is the short message channel
    assign short_message = (channel == 14'h0000) && (chan_cnt_reg == 2'h1); // [RULE21]
    assign data_len      = dcnt_reg;

    // ------------------------------------------------------------
    // Result pulses and held alert code
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_ack              <= 1'b0;
            rx_accept           <= 1'b0;
            rx_forward          <= 1'b0;
            link_error_recovery <= 1'b0;
            alert_code          <= tfhs_pkg::ALERT_NONE;
            total_reset         <= 1'b0;
            absolute_reset      <= 1'b0;
            power_on_self_test  <= 1'b0;
            link_reset_rx       <= 1'b0;
        end else begin
            rx_ack        <= good_w && !router_mode;                  // [RULE7]
            rx_accept     <= good_w && !router_mode;
            rx_forward    <= fwd_w;                                   // [RULE11]
            link_error_recovery <= erp_w;                             // [RULE8]
            // Reject outranks a sequence error
            if (erp_w) begin
                alert_code <= other_err_w ? tfhs_pkg::ALERT_REJECT : tfhs_pkg::ALERT_SEQ; // [RULE12]
            end
            total_reset    <= ctrl_ok_w && (rtype_reg == tfhs_pkg::RT_TOTAL ||
                                            rtype_reg == tfhs_pkg::RT_ABS); // [RULE3]
            absolute_reset <= ctrl_ok_w && rtype_reg == tfhs_pkg::RT_ABS;   // [RULE2]
            power_on_self_test <= ctrl_ok_w && rtype_reg == tfhs_pkg::RT_ABS;
            link_reset_rx  <= ctrl_ok_w && rtype_reg == tfhs_pkg::RT_LINK;
        end
    end

    // Receive counter; total reset also clears it
    always_ff @(posedge clk) begin
        if (!rst_n || link_disabled || total_reset) begin
            rx_seq <= SEQ_W'(tfhs_pkg::SEQ_RESET);                    // [RULE6]
        end else if (seq_adv_w) begin
            rx_seq <= rx_seq + SEQ_W'(1);                             // [RULE10]
        end
    end

    // ------------------------------------------------------------
    // Transmit path: two-entry skid buffer with sequence insertion
    // ------------------------------------------------------------
    logic [7:0] buf_reg [2];
    logic [1:0] cnt_reg;
    logic       tx_ctrl_reg;
    logic       tx_open_reg;
    wire logic  push_w = tx_in_valid && tx_in_ready;
    wire logic  pop_w  = tx_out_valid && tx_out_ready;
    wire logic  tx_hdr_ctrl_w = tx_in_byte[tfhs_pkg::FT_POS +: 2] == tfhs_pkg::FT_CTRL;
    // Control bytes of sequenced frames get our counter, forwarded ones too
    wire logic [7:0] tx_ins_w = (tx_in_first && !tx_hdr_ctrl_w) ?
                                {tx_in_byte[7:2], tx_seq[1:0]} : tx_in_byte; // [RULE4] [RULE9]

    assign tx_in_ready  = (cnt_reg != 2'h2);
    assign tx_out_valid = (cnt_reg != 2'h0);
    assign tx_out_byte  = buf_reg[0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg    <= 2'h0;
            buf_reg[0] <= 8'h00;
            buf_reg[1] <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + {1'b0, push_w} - {1'b0, pop_w};
            if (pop_w) begin
                buf_reg[0] <= (cnt_reg == 2'h2) ? buf_reg[1] : tx_ins_w;
            end else if (push_w && cnt_reg == 2'h0) begin
                buf_reg[0] <= tx_ins_w;
            end
            if (push_w && ((cnt_reg == 2'h1 && !pop_w) || cnt_reg == 2'h2)) begin
                buf_reg[1] <= tx_ins_w;
            end
        end
    end

    // Transmit counter follows the frame type of the frame in flight
    always_ff @(posedge clk) begin
        if (!rst_n || link_disabled || total_reset) begin
            tx_seq      <= SEQ_W'(tfhs_pkg::SEQ_RESET);               // [RULE4]
            tx_ctrl_reg <= 1'b0;
            tx_open_reg <= 1'b0;
        end else begin
            if (push_w && tx_in_first) begin
                tx_ctrl_reg <= tx_hdr_ctrl_w;
                tx_open_reg <= 1'b1;
            end else if (tx_end || tx_abort) begin
                tx_open_reg <= 1'b0;
            end
            if (tx_end && !tx_abort && tx_open_reg && !tx_ctrl_reg) begin
                tx_seq <= tx_seq + SEQ_W'(1);                          // [RULE5]
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_seq_mismatch: assert property (@(posedge clk) disable iff (!rst_n)   // [RULE8]
        (rx_end && !rx_abort && rx_crc_ok && seq_bad_reg && !router_mode)
        |=> link_error_recovery && !rx_ack) else $error("mismatch not reported");
    a_rx_advance: assert property (@(posedge clk) disable iff (!rst_n)     // [RULE6]
        (is_ctrl_w || rx_abort) && !link_disabled && !total_reset
        |=> $stable(rx_seq)) else $error("rx counter moved");
    a_tx_advance: assert property (@(posedge clk) disable iff (!rst_n)     // [RULE5]
        (tx_end && !tx_abort && tx_open_reg && !tx_ctrl_reg && !link_disabled && !total_reset)
        |=> tx_seq == $past(tx_seq) + SEQ_W'(1)) else $error("tx counter stuck");
    a_tx_clear: assert property (@(posedge clk) disable iff (!rst_n)       // [RULE4]
        link_disabled |=> tx_seq == '0 && rx_seq == '0) else $error("counter not cleared");
    a_reject_code: assert property (@(posedge clk) disable iff (!rst_n)    // [RULE12]
        (frame_end_w && reject_reg && !router_mode)
        |=> alert_code == tfhs_pkg::ALERT_REJECT) else $error("reject code wrong");
    a_ack_ok: assert property (@(posedge clk) disable iff (!rst_n)         // [RULE7]
        rx_ack |-> !$past(seq_bad_reg) && !$past(is_ctrl_w)) else $error("bad ack");
    a_abs_total: assert property (@(posedge clk) disable iff (!rst_n)      // [RULE3]
        absolute_reset |-> total_reset) else $error("absolute without total");
    a_buf_hold: assert property (@(posedge clk) disable iff (!rst_n)       // [RULE9]
        tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out_byte))
        else $error("buffer lost word");
endmodule : tfhs_frame

/* File: bench/tfhs_far_node.sv */
// Far-end node model: sends frames into the block and drains its output
`timescale 1ns/1ns
module tfhs_far_node (
    input  wire logic       clk,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_start,
    output logic            rx_end,
    output logic            rx_abort,
    output logic            rx_crc_ok,
    output logic            rx_last_xfer,
    input  wire logic       tx_out_valid,
    input  wire logic [7:0] tx_out_byte,
    output logic            tx_out_ready
);
    logic       stall = 1'h0;
    logic       crc_bad = 1'h0;  // Set by the bench to spoil one frame's check
    logic [7:0] got [$];
    initial {rx_valid, rx_start, rx_end, rx_abort, rx_crc_ok, rx_last_xfer} = 6'h00;
    initial {tx_out_ready, rx_byte} = 9'h15A;
    // Output side: stalls on request and keeps every accepted word
    always @(posedge clk) begin
        if (tx_out_valid && tx_out_ready)
            got.push_back(tx_out_byte);
        tx_out_ready <= !stall;
    end
    // Control byte leads, then address and data follow it
    task put(input logic [7:0] b, input logic first);
        @(posedge clk);
        rx_valid <= 1'h1;
        rx_start <= first;
        rx_byte  <= b;
    endtask : put
    // Trailing flag sits alone; the released data line keeps toggling
    task close(input logic last, input logic ab);
        @(posedge clk);
        {rx_valid, rx_start} <= 2'h0;
        rx_byte <= ~rx_byte;
        {rx_end, rx_abort, rx_crc_ok, rx_last_xfer} <= {!ab, ab, !crc_bad, last};
        @(posedge clk);
        {rx_end, rx_abort} <= 2'h0;
        rx_byte <= ~rx_byte;
        @(negedge clk);
    endtask : close
endmodule : tfhs_far_node

/* File: bench/test_transport_frame_header_seq.sv */
// Testbench: header parsing, sequence counters and transmit buffering
`timescale 1ns/1ns
module test_transport_frame_header_seq;
    logic        clk, rst_n, link_disabled, ext_enable, router_mode, rx_valid, rx_start;
    logic        rx_end, rx_abort, rx_crc_ok, rx_last_xfer, tx_in_valid, tx_in_ready;
    logic        tx_in_first, tx_end, tx_abort, tx_out_valid, tx_out_ready, rx_ack;
    logic        rx_accept, rx_forward, link_error_recovery, total_reset, absolute_reset;
    logic        power_on_self_test, link_reset_rx, short_message;
    logic [7:0]  rx_byte, tx_in_byte, tx_out_byte, link_status, ext_rx_count_field, data_len;
    logic [1:0]  alert_code, tx_seq, rx_seq;
    logic [6:0]  path_index [tfhs_pkg::PATH_MAX];
    logic [2:0]  path_len;
    logic [13:0] channel;
    int          n_fail = 0, compares = 0, cycles = 0;

    tfhs_frame #(.SEQ_W(2)) uut (
        .clk, .rst_n, .link_disabled, .ext_enable, .router_mode, .rx_valid, .rx_byte,
        .rx_start, .rx_end, .rx_abort, .rx_crc_ok, .rx_last_xfer, .tx_in_valid,
        .tx_in_ready, .tx_in_byte, .tx_in_first, .tx_end, .tx_abort, .tx_out_valid,
        .tx_out_ready, .tx_out_byte, .rx_ack, .rx_accept, .rx_forward,
        .link_error_recovery, .alert_code, .total_reset, .absolute_reset,
        .power_on_self_test, .link_reset_rx, .link_status, .ext_rx_count_field,
        .path_index, .path_len, .channel, .short_message, .data_len, .tx_seq, .rx_seq);
    tfhs_far_node far (
        .clk, .rx_valid, .rx_byte, .rx_start, .rx_end, .rx_abort, .rx_crc_ok,
        .rx_last_xfer, .tx_out_valid, .tx_out_byte, .tx_out_ready);

    always #2 clk = ~clk;
    // Cycle ceiling, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task give_verdict;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Header bytes come from the top of h; data bytes count up from 1
    task rx(input logic [31:0] h, input int nh, input int nd, input logic last, input logic ab);
        for (int i = 0; i < nh; i++) far.put(h[31-8*i -: 8], i == 0);
        for (int i = 0; i < nd; i++) far.put(8'(i + 1), 1'h0);
        far.close(last, ab);
    endtask : rx
    task res(input logic [3:0] exp, input logic [1:0] s);
        check("ack accept err fwd", {rx_ack, rx_accept, link_error_recovery, rx_forward}, exp);
        check("rx_seq", rx_seq, s);
    endtask : res
    // Holds the word until a negedge shows ready, so the next edge takes it
    task push(input logic [7:0] b, input logic first);
        @(posedge clk);
        {tx_in_valid, tx_in_first, tx_in_byte} <= {1'h1, first, b};
        @(negedge clk);
        for (int t = 0; t < 50 && tx_in_ready !== 1'h1; t++) @(negedge clk);
        @(posedge clk);
        {tx_in_valid, tx_in_first} <= 2'h0;
        @(negedge clk);
    endtask : push
    task tx_close(input logic ab, input logic [1:0] s);
        @(posedge clk);
        {tx_end, tx_abort} <= {!ab, ab};
        @(posedge clk);
        {tx_end, tx_abort} <= 2'h0;
        @(negedge clk);
        check("tx_seq", tx_seq, s);
    endtask : tx_close
    task tx_frame(input logic [7:0] b, input logic [7:0] exp, input logic ab, input logic [1:0] s);
        far.got.delete();
        push(b, 1'h1);
        for (int t = 0; t < 20 && far.got.size() < 1; t++) @(negedge clk);
        check("tx byte", far.got[0], exp);
        tx_close(ab, s);
    endtask : tx_frame

    // Main sequence; reset held for two edges
    initial begin
        clk = 1'h0;
        tx_in_byte = 8'h00;
        {rst_n, link_disabled, ext_enable, router_mode, tx_in_valid, tx_in_first} = 6'h00;
        {tx_end, tx_abort} = 2'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(negedge clk);
        check("idle", {tx_in_ready, tx_seq, rx_seq}, 5'h10);
        $display("test reset done");
        for (int k = 0; k < 5; k++) begin
            rx({4'h0, k[0], 1'h0, k[1:0], 24'h0}, 3, 0, 1'h1, 1'h0);
            res(4'hC, 2'(k + 1));
            check("short", {short_message, path_len}, 4'h9);
        end
        rx(32'h0300_0000, 3, 0, 1'h1, 1'h0);
        res(4'h2, 2'h1);
        check("alert", alert_code, tfhs_pkg::ALERT_SEQ);
        rx(32'h0100_0000, 3, 2, 1'h1, 1'h1);
        res(4'h0, 2'h1);
        far.crc_bad <= 1'h1;
        rx(32'h0100_0000, 3, 0, 1'h1, 1'h0);
        far.crc_bad <= 1'h0;
        res(4'h0, 2'h1);
        $display("test receive sequence done");
        for (int r = 0; r < 4; r++) begin
            rx({8'h0C | 8'(r), 24'h0}, 2, 0, 1'h1, 1'h0);
            check("reset kind", {link_reset_rx, absolute_reset}, {r == 0, r == 3});
            if (r == 1) check("total", {total_reset, power_on_self_test}, 2'h2);
            if (r == 3) check("self test", {total_reset, power_on_self_test}, 2'h3);
            if (r == 2) check("reject", alert_code, tfhs_pkg::ALERT_REJECT);
        end
        check("rx_seq", rx_seq, 2'h0);
        rx(32'h0200_0000, 3, 0, 1'h1, 1'h0);
        check("alert", alert_code, tfhs_pkg::ALERT_SEQ);
        rx(32'h0400_0000, 3, 0, 1'h1, 1'h0);
        res(4'h2, 2'h0);
        check("alert", alert_code, tfhs_pkg::ALERT_REJECT);
        @(posedge clk);
        ext_enable <= 1'h1;
        rx(32'h0CA5_9600, 3, 0, 1'h1, 1'h0);
        check("status", {link_status, ext_rx_count_field}, 16'hA596);
        $display("test control frames done");
        rx(32'h0000_8105, 4, 8, 1'h0, 1'h0);
        res(4'hC, 2'h1);
        check("channel", channel, 14'h0085);
        check("path", {path_len, path_index[0]}, 10'h080);
        check("data", {short_message, data_len}, 9'h008);
        rx(32'h0100_0500, 3, 3, 1'h0, 1'h0);
        res(4'h2, 2'h1);
        rx(32'h0100_0500, 3, 3, 1'h1, 1'h0);
        res(4'hC, 2'h2);
        check("data_len", data_len, 8'h03);
        @(posedge clk);
        {ext_enable, router_mode} <= 2'h1;
        rx(32'h0281_0300, 4, 0, 1'h1, 1'h0);
        check("forward", {rx_forward, rx_accept}, 2'h2);
        check("route", {path_len[1:0], path_index[0], path_index[1]}, 16'h8003);
        @(posedge clk);
        {router_mode, far.stall} <= 2'h1;
        rx(32'h0300_0000, 3, 40, 1'h1, 1'h0);
        res(4'h2, 2'h3);
        $display("test address and data done");
        repeat (2) @(posedge clk);
        push(8'h08, 1'h1);
        push(8'h33, 1'h0);
        check("full", {tx_in_ready, tx_out_valid, tx_out_byte}, 10'h108);
        @(posedge clk);
        far.stall <= 1'h0;
        for (int t = 0; t < 20 && far.got.size() < 2; t++) @(negedge clk);
        check("drain", {far.got[0], far.got[1]}, 16'h0833);
        check("empty", {tx_out_valid, tx_in_ready}, 2'h1);
        tx_close(1'h0, 2'h1);
        tx_frame(8'h08, 8'h09, 1'h0, 2'h2);
        tx_frame(8'h0D, 8'h0D, 1'h0, 2'h2);
        tx_frame(8'h00, 8'h02, 1'h1, 2'h2);
        tx_frame(8'h04, 8'h06, 1'h0, 2'h3);
        @(posedge clk);
        link_disabled <= 1'h1;
        @(posedge clk);
        link_disabled <= 1'h0;
        @(negedge clk);
        check("cleared", {tx_seq, rx_seq}, 4'h0);
        $display("test transmit done");
        give_verdict();
    end
endmodule : test_transport_frame_header_seq
